// >>> inc/pmcr_map.vh
// Register map, field positions and reset values of the power and clock control register
`ifndef PMCR_MAP_VH
`define PMCR_MAP_VH

`define PMCR_ADDR_CTRL 16'h2000
`define PMCR_MULT_LSB 0
`define PMCR_MULT_MSB 5
`define PMCR_POSTDIV_LSB 6
`define PMCR_POSTDIV_MSB 7
`define PMCR_HALVER_BIT 8
`define PMCR_LOAD_BIT 9
`define PMCR_OUTSEL_BIT 12
`define PMCR_BYPASS_BIT 15
`define PMCR_RATIO_LSB 16
`define PMCR_RATIO_MSB 17
`define PMCR_PARPORT_BIT 26
`define PMCR_SPORT01_BIT 27
`define PMCR_SPORT23_BIT 28
`define PMCR_SPORT45_BIT 29
`define PMCR_SPI_BIT 30
`define PMCR_TIMER_BIT 31
`define PMCR_MULT_CFG0 6'h06
`define PMCR_MULT_CFG1 6'h20
`define PMCR_MULT_CFG2 6'h10
`define PMCR_MULT_CFG3 6'h06
`define PMCR_MULT_ZERO_VAL 7'h40
`define PMCR_POSTDIV_RESET 2'h0

`endif

// >>> hw/pmcr_top.v
// Power management control register with APB slave, clock gates and output pin mux
`timescale 1ns/1ps
`include "pmcr_map.vh"

module pmcr_top #(
   parameter ADDR_W = 16
) (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Clock configuration pins
   input wire [1:0] cfg_pins,
   // PLL control
   output reg [6:0] pll_mult,
   output reg [4:0] post_div_ratio,
   output reg input_halver,
   output reg pll_bypass,
   // Shared output pin
   input wire core_freq_out_pin,
   input wire rst_out_pin,
   output reg shared_out_pin,
   // Peripheral clock enables, high while the clock runs; flag_pins_usable follows the SPI clock enable
   output reg parport_clk_en,
   output reg sport01_clk_en,
   output reg sport23_clk_en,
   output reg sport45_clk_en,
   output reg spi_clk_en,
   output reg timer_clk_en,
   output reg flag_pins_usable
);

   localparam [1:0] ST_RESET = 2'h0;
   localparam [1:0] ST_STRAP = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;
   localparam [1:0] ST_FILL = 2'h3;

   // Pin synchronisers, three stages
   reg [1:0] cfg_s1_reg, cfg_s2_reg, cfg_s3_reg;
   reg src_s1_reg, src_s2_reg, src_s3_reg;
   reg rst_s1_reg, rst_s2_reg, rst_s3_reg;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [5:0] mult_reg;
   reg [1:0] post_div_field_reg;
   reg input_halver_reg;
   reg out_pin_select_reg;
   reg pll_bypass_reg;
   reg [1:0] cfg_ratio_status_reg;
   reg [5:0] gate_reg;
   reg clk_src_reg;
   reg rst_src_reg;

   wire sel_ctrl;
   wire acc_wr;
   reg [31:0] rd_word;
   wire strap_now;
   wire lane0_wr;
   wire lane1_wr;
   wire lane3_wr;
   wire div_load;

   // Multiplier default for each configuration pin pattern
   function [5:0] mult_default;
      input [1:0] cfg;
      begin
         case (cfg)
            2'h0: mult_default = `PMCR_MULT_CFG0;
            2'h1: mult_default = `PMCR_MULT_CFG1;
            2'h2: mult_default = `PMCR_MULT_CFG2;
            default: mult_default = `PMCR_MULT_CFG3;
         endcase
      end
   endfunction

   assign sel_ctrl = (paddr == `PMCR_ADDR_CTRL);
   assign acc_wr = psel & penable & pwrite & sel_ctrl;

   // Write enable of one byte lane of the control register
   function lane_hit;
      input wr;
      input [3:0] strb;
      input [1:0] idx;
      begin
         lane_hit = wr & strb[idx];
      end
   endfunction

   // Strap cycle wins: a bus write landing in that cycle is lost
   assign strap_now = (state_reg == ST_STRAP) & (state_next == ST_RUN);
   assign lane0_wr = lane_hit(acc_wr & ~strap_now, pstrb, 2'h0);
   assign lane1_wr = lane_hit(acc_wr & ~strap_now, pstrb, 2'h1);
   assign lane3_wr = lane_hit(acc_wr & ~strap_now, pstrb, 2'h3);
   // Load bit and the field it loads sit in different lanes, so both must be written
   assign div_load = lane0_wr & lane1_wr & pwdata[`PMCR_LOAD_BIT];

   // Load bit and reserved bits read as zero
   always @* begin
      rd_word = 32'h0000_0000;
      rd_word[`PMCR_MULT_MSB:`PMCR_MULT_LSB] = mult_reg;
      rd_word[`PMCR_POSTDIV_MSB:`PMCR_POSTDIV_LSB] = post_div_field_reg;
      rd_word[`PMCR_HALVER_BIT] = input_halver_reg;
      rd_word[`PMCR_OUTSEL_BIT] = out_pin_select_reg;
      rd_word[`PMCR_BYPASS_BIT] = pll_bypass_reg;
      rd_word[`PMCR_RATIO_MSB:`PMCR_RATIO_LSB] = cfg_ratio_status_reg;
      rd_word[`PMCR_PARPORT_BIT] = gate_reg[0];
      rd_word[`PMCR_SPORT01_BIT] = gate_reg[1];
      rd_word[`PMCR_SPORT23_BIT] = gate_reg[2];
      rd_word[`PMCR_SPORT45_BIT] = gate_reg[3];
      rd_word[`PMCR_SPI_BIT] = gate_reg[4];
      rd_word[`PMCR_TIMER_BIT] = gate_reg[5];
   end

   // Configuration pins, three stages; strapping waits for stages two and three to agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_s1_reg <= 2'h0;
         cfg_s2_reg <= 2'h0;
         cfg_s3_reg <= 2'h0;
      end else begin
         cfg_s1_reg <= cfg_pins;
         cfg_s2_reg <= cfg_s1_reg;
         cfg_s3_reg <= cfg_s2_reg;
      end
   end

   // Clock mux source, a change counts only once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_s1_reg <= 1'b0;
         src_s2_reg <= 1'b0;
         src_s3_reg <= 1'b0;
         clk_src_reg <= 1'b0;
      end else begin
         src_s1_reg <= core_freq_out_pin;
         src_s2_reg <= src_s1_reg;
         src_s3_reg <= src_s2_reg;
         if (src_s2_reg == src_s3_reg) begin
            clk_src_reg <= src_s3_reg;
         end
      end
   end

   // Reset mux source, same filtering as the clock source
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
         rst_s3_reg <= 1'b0;
         rst_src_reg <= 1'b0;
      end else begin
         rst_s1_reg <= rst_out_pin;
         rst_s2_reg <= rst_s1_reg;
         rst_s3_reg <= rst_s2_reg;
         if (rst_s2_reg == rst_s3_reg) begin
            rst_src_reg <= rst_s3_reg;
         end
      end
   end

   // Synchroniser is cleared by reset, so ST_RESET and one ST_FILL state pass before ST_STRAP waits for stages to agree on the pins
   always @* begin
      case (state_reg)
         ST_RESET: state_next = ST_FILL;
         ST_FILL: state_next = ST_STRAP;
         ST_STRAP: state_next = (cfg_s2_reg == cfg_s3_reg) ? ST_RUN : ST_STRAP;
         ST_RUN: state_next = ST_RUN;
         default: state_next = ST_RESET;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mult_reg <= `PMCR_MULT_CFG0;
      end else if (strap_now) begin
         mult_reg <= mult_default(cfg_s3_reg);
      end else if (lane0_wr) begin
         mult_reg <= pwdata[`PMCR_MULT_MSB:`PMCR_MULT_LSB];
      end
   end

   // Status field is never written from the bus
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ratio_status_reg <= 2'h0;
      end else if (strap_now) begin
         cfg_ratio_status_reg <= cfg_s3_reg;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_div_field_reg <= `PMCR_POSTDIV_RESET;
      end else if (div_load) begin
         post_div_field_reg <= pwdata[`PMCR_POSTDIV_MSB:`PMCR_POSTDIV_LSB];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_halver_reg <= 1'b0;
      end else if (lane1_wr) begin
         input_halver_reg <= pwdata[`PMCR_HALVER_BIT];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_pin_select_reg <= 1'b0;
      end else if (lane1_wr) begin
         out_pin_select_reg <= pwdata[`PMCR_OUTSEL_BIT];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_bypass_reg <= 1'b0;
      end else if (lane1_wr) begin
         pll_bypass_reg <= pwdata[`PMCR_BYPASS_BIT];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_reg <= 6'h00;
      end else if (lane3_wr) begin
         gate_reg <= pwdata[`PMCR_TIMER_BIT:`PMCR_PARPORT_BIT];
      end
   end

   // APB answer: zero wait states, ready in the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~sel_ctrl;
      end
   end

   // Read data captured in the setup cycle, so it stands through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite & sel_ctrl) begin
         prdata <= rd_word;
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   // Outputs held in flip-flops, one cycle behind the register fields
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_mult <= `PMCR_MULT_ZERO_VAL;
      end else begin
         pll_mult <= (mult_reg == 6'h00) ? `PMCR_MULT_ZERO_VAL : {1'b0, mult_reg};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_div_ratio <= 5'h02;
      end else begin
         post_div_ratio <= 5'h02 << post_div_field_reg;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_halver <= 1'b0;
      end else begin
         input_halver <= input_halver_reg;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_bypass <= 1'b0;
      end else begin
         pll_bypass <= pll_bypass_reg;
      end
   end

   // Pin mux follows the filtered sources, so a glitch of one pclk cycle on a source pin never reaches it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_out_pin <= 1'b0;
      end else begin
         shared_out_pin <= out_pin_select_reg ? clk_src_reg : rst_src_reg;
      end
   end

   // Clock enables, high while the peripheral clock runs; flag_pins_usable copies the SPI enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parport_clk_en <= 1'b1;
         sport01_clk_en <= 1'b1;
         sport23_clk_en <= 1'b1;
         sport45_clk_en <= 1'b1;
         spi_clk_en <= 1'b1;
         timer_clk_en <= 1'b1;
         flag_pins_usable <= 1'b1;
      end else begin
         parport_clk_en <= ~gate_reg[0];
         sport01_clk_en <= ~gate_reg[1];
         sport23_clk_en <= ~gate_reg[2];
         sport45_clk_en <= ~gate_reg[3];
         spi_clk_en <= ~gate_reg[4];
         flag_pins_usable <= ~gate_reg[4];
         timer_clk_en <= ~gate_reg[5];
      end
   end

endmodule // pmcr_top

// >>> bench/pmcr_assertions.sv
// Port-level assertions for the power and clock control register
`timescale 1ns/1ps
module pmcr_assertions (
   // Bus side
   input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire [15:0] paddr,
   input wire [31:0] pwdata, prdata,
   // Control outputs
   input wire [6:0] pll_mult,
   input wire [4:0] post_div_ratio,
   input wire spi_clk_en, flag_pins_usable, timer_clk_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready;
   wire wr_reg = acc && pwrite && paddr == 16'h2000;
   a_err_addr: assert property (
      acc |-> pslverr == (paddr != 16'h2000)) else $error("slave error flag wrong");
   a_err_data: assert property (
      acc && pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_read_zero: assert property (
      acc && !pwrite |-> (prdata & 32'h03FC_6E00) == 32'h0000_0000) else $error("zero bits read set");
   a_mult_zero: assert property (
      $past(wr_reg && pwdata[5:0] == 6'h00, 2) |-> pll_mult == 7'h40) else $error("zero multiplier not 64");
   a_div_code: assert property (
      post_div_ratio inside {5'h02, 5'h04, 5'h08, 5'h10}) else $error("divider ratio illegal");
   a_div_load: assert property (
      $changed(post_div_ratio) |-> $past(wr_reg && pwdata[9], 2)) else $error("divider changed unloaded");
   a_flag_spi: assert property (
      flag_pins_usable == spi_clk_en) else $error("flag pins not tied to spi clock");
   a_gate_write: assert property (
      $changed(timer_clk_en) |-> $past(wr_reg, 2)) else $error("timer gate moved unwritten");
endmodule // pmcr_assertions

bind pmcr_top pmcr_assertions u_chk (.*);

// >>> bench/pmcr_tb.sv
// Self-checking bench for the power and clock control register
`timescale 1ns/1ps
`define CHK(n, x, v) begin checked++; if ((v) !== (x)) begin num_errors++; $display("wrong value %s exp %h got %h", n, x, v); end end
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, core_freq_out_pin = 0, rst_out_pin = 1;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, rd;
   logic [3:0] pstrb = 4'hF;
   logic [1:0] cfg_pins = 2'h0;
   logic [5:0] mt [4] = '{6'h06, 6'h20, 6'h10, 6'h06};
   int num_errors = 0, checked = 0, cyc = 0;
   wire [31:0] prdata;
   wire [6:0] pll_mult;
   wire [4:0] post_div_ratio;
   wire pready, pslverr, input_halver, pll_bypass, shared_out_pin, flag_pins_usable, parport_clk_en;
   wire sport01_clk_en, sport23_clk_en, sport45_clk_en, spi_clk_en, timer_clk_en;
   wire [5:0] gates = {timer_clk_en, spi_clk_en, sport45_clk_en, sport23_clk_en, sport01_clk_en, parport_clk_en};
   wire [2:0] misc = {input_halver, pll_bypass, flag_pins_usable};
   pmcr_top u_dut (.*);
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   task results();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Pins pass a three-stage synchroniser, so allow a few edges
   task settle();
      repeat (5) @(posedge pclk);
   endtask
   task t_strap();
      for (int c = 0; c < 4; c++) begin
         presetn <= 1'b0;
         cfg_pins <= c[1:0];
         repeat (6) @(posedge pclk);
         presetn <= 1'b1;
         repeat (8) @(posedge pclk);
         apb(1'b0, 16'h2000, 32'h0000_0000);
         `CHK("word", {14'h0, c[1:0], 10'h0, mt[c]}, rd)
         `CHK("mult", {1'b0, mt[c]}, pll_mult)
         `CHK("gates", 6'h3F, gates)
         `CHK("div", 5'h02, post_div_ratio)
         `CHK("misc", 3'b001, misc)
         `CHK("pin", rst_out_pin, shared_out_pin)
      end
      $display("strap test done");
   endtask
   task t_fields();
      apb(1'b1, 16'h2000, 32'hFFFF_FFFF);
      apb(1'b0, 16'h2000, 32'h0000_0000);
      `CHK("ones", 32'hFC03_91FF, rd)
      settle();
      `CHK("mult", 7'h3F, pll_mult)
      `CHK("gates", 6'h00, gates)
      `CHK("misc", 3'b110, misc)
      `CHK("pin", core_freq_out_pin, shared_out_pin)
      core_freq_out_pin <= 1'b1;
      settle();
      settle();
      `CHK("pin high", 1'b1, shared_out_pin)
      apb(1'b1, 16'h2000, 32'h0000_00C0);
      settle();
      `CHK("mult", 7'h40, pll_mult)
      `CHK("div", 5'h10, post_div_ratio)
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 16'h2000, 32'h0000_0200 | (k << 6));
         settle();
         `CHK("div", 5'h02 << k, post_div_ratio)
      end
      for (int b = 0; b < 6; b++) begin
         apb(1'b1, 16'h2000, (32'h0400_0000 << b) | 32'h0000_00C0);
         settle();
         `CHK("gate", ~(6'h01 << b), gates)
      end
      $display("field test done");
   endtask
   task t_unmapped();
      apb(1'b1, 16'h2004, 32'hFFFF_FFFF);
      `CHK("err", 1'b1, e)
      apb(1'b0, 16'h2004, 32'h0000_0000);
      `CHK("err read", 33'h1_0000_0000, {e, rd})
      apb(1'b0, 16'h2000, 32'h0000_0000);
      `CHK("kept", 33'h0_8003_00C0, {e, rd})
      $display("unmapped test done");
   endtask
   initial begin
      t_strap();
      t_fields();
      t_unmapped();
      results();
   end
endmodule // testbench
